/* File: common/tsr_pkg.sv */
package tsr_pkg;

  // ****************************************
  // Register selection and layout
  // ****************************************
  localparam logic [7:0] CMD_TEMP       = 8'h00;
  localparam logic [7:0] CMD_CONFIG     = 8'h01;
  localparam int         CFG_STANDBY    = 7;
  localparam int         CFG_READY      = 6;
  localparam logic [7:0] TEMP_RESET     = 8'h00;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam logic [5:0] CFG_RSVD_VALUE = 6'h00;

  // ****************************************
  // Temperature coding
  // ****************************************
  localparam logic [7:0] TEMP_MAX = 8'h7F;
  localparam logic [7:0] TEMP_MIN = 8'h80;

  // ****************************************
  // Serial port
  // ****************************************
  localparam logic [6:0] DEV_ADDR  = 7'h4D;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // ****************************************
  // Conversion timing
  // ****************************************
  localparam int CONV_PERIOD_US = 125000;
  localparam int CLK_FREQ_MHZ   = 40;
  localparam int CONV_CYCLES    = CONV_PERIOD_US * CLK_FREQ_MHZ;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_WDATA,
    ST_ACK,
    ST_READ,
    ST_RACK
  } tsr_state_t;

endpackage

/* File: common/tsr_conv_if.sv */
`timescale 1ns/1ps
interface tsr_conv_if;
  logic       standby;
  logic       result_valid;
  logic [7:0] result_code;

  modport regs (
    output standby,
    input  result_valid,
    input  result_code
  );

  modport conv (
    input  standby,
    output result_valid,
    output result_code
  );
endinterface

/* File: hw/tsr_conv.sv */
`timescale 1ns/1ps
module tsr_conv #(
  parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES,
  parameter int SENSE_W     = 12,
  parameter int FRAC_W      = 2
) (
  // Clock and reset
  input  wire logic               sys_clk_i,
  input  wire logic               rst_i,
  // Sensor sample, same clock domain
  input  wire logic signed [SENSE_W-1:0] sensor_temp_i,
  // Link to register set
  tsr_conv_if.conv                conv
);

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);
  localparam int WHOLE_W = SENSE_W - FRAC_W;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  logic             valid_reg;
  logic [7:0]       code_reg;
  logic [7:0]       code_next;

  // ****************************************
  // Quantise: floor to whole degree, saturate
  // ****************************************
  wire logic signed [WHOLE_W-1:0] whole;
  assign whole = WHOLE_W'(sensor_temp_i >>> FRAC_W);
  wire logic                      too_hot = whole > $signed(WHOLE_W'(127));
  wire logic                      too_cold = whole < $signed(-WHOLE_W'(128));
  wire logic                      conv_end = (cnt_reg == CNT_LAST)
                                             && !conv.standby;

  assign cnt_next  = conv.standby ? '0 :
                     conv_end ? '0 : cnt_reg + CNT_W'(1);
  assign code_next = too_hot  ? tsr_pkg::TEMP_MAX :
                     too_cold ? tsr_pkg::TEMP_MIN :
                     whole[7:0];

  assign conv.result_valid = valid_reg;
  assign conv.result_code  = code_reg;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cnt_reg   <= '0;
      valid_reg <= 1'b0;
      code_reg  <= tsr_pkg::TEMP_RESET;
    end else begin
      cnt_reg   <= cnt_next;
      valid_reg <= conv_end;
      if (conv_end) begin
        code_reg <= code_next;
      end
    end
  end

endmodule

/* File: hw/tsr_sensor_top.sv */
`timescale 1ns/1ps
module tsr_sensor_top #(
  parameter logic [6:0] DEV_ADDR    = tsr_pkg::DEV_ADDR,
  parameter int         CONV_CYCLES = tsr_pkg::CONV_CYCLES,
  parameter int         SENSE_W     = 12,
  parameter int         FRAC_W      = 2
) (
  // Clock and reset
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_i,
  // Two-wire serial port
  input  wire logic                      scl_i,
  input  wire logic                      sda_i,
  output logic                           sda_o,
  output logic                           sda_oe_o,
  // Sensor sample, same clock domain
  input  wire logic signed [SENSE_W-1:0] sensor_temp_i,
  // Status
  output logic                           standby_o,
  output logic                           data_ready_o
);

  // ****************************************
  // Declarations
  // ****************************************
  tsr_conv_if conv_bus ();

  logic                scl_meta_reg;
  logic                scl_sync_reg;
  logic                scl_prev_reg;
  logic                sda_meta_reg;
  logic                sda_sync_reg;
  logic                sda_prev_reg;

  tsr_pkg::tsr_state_t state_reg;
  tsr_pkg::tsr_state_t state_next;
  tsr_pkg::tsr_state_t after_reg;
  tsr_pkg::tsr_state_t after_next;
  logic [3:0]          cnt_reg;
  logic [3:0]          cnt_next;
  logic [7:0]          shift_reg;
  logic [7:0]          shift_next;
  logic                oe_reg;
  logic                oe_next;
  logic                ptr_cfg_reg;
  logic                ptr_cfg_next;
  logic                acked_reg;
  logic                acked_next;
  logic                standby_reg;
  logic                standby_next;
  logic                ready_reg;
  logic                ready_next;
  logic                load_pend_reg;
  logic [7:0]          temp_reg;
  logic                sda_out_reg;

  // ****************************************
  // Conversion engine
  // ****************************************
  tsr_conv #(
    .CONV_CYCLES (CONV_CYCLES),
    .SENSE_W     (SENSE_W),
    .FRAC_W      (FRAC_W)
  ) u_conv (
    .sys_clk_i     (sys_clk_i),
    .rst_i         (rst_i),
    .sensor_temp_i (sensor_temp_i),
    .conv          (conv_bus.conv)
  );

  assign conv_bus.standby = standby_reg;

  // ****************************************
  // Line conditions
  // ****************************************
  wire logic scl_rise  = scl_sync_reg & ~scl_prev_reg;
  wire logic scl_fall  = ~scl_sync_reg & scl_prev_reg;
  wire logic start_det = scl_sync_reg & scl_prev_reg
                         & sda_prev_reg & ~sda_sync_reg;
  wire logic stop_det  = scl_sync_reg & scl_prev_reg
                         & ~sda_prev_reg & sda_sync_reg;
  wire logic byte_done = scl_fall && (cnt_reg == tsr_pkg::BYTE_BITS);
  wire logic addr_hit  = shift_reg[7:1] == DEV_ADDR;
  wire logic cmd_temp  = shift_reg == tsr_pkg::CMD_TEMP;
  wire logic cmd_cfg   = shift_reg == tsr_pkg::CMD_CONFIG;

  // ****************************************
  // Register read selection
  // ****************************************
  wire logic [7:0] cfg_view = {standby_reg, ready_reg,
                               tsr_pkg::CFG_RSVD_VALUE};
  wire logic [7:0] rd_data  = ptr_cfg_reg ? cfg_view : temp_reg;

  // ****************************************
  // Serial slave sequencing
  // ****************************************
  always_comb begin
    state_next   = state_reg;
    after_next   = after_reg;
    cnt_next     = cnt_reg;
    shift_next   = shift_reg;
    oe_next      = oe_reg;
    ptr_cfg_next = ptr_cfg_reg;
    acked_next   = acked_reg;
    standby_next = standby_reg;
    if (start_det) begin
      state_next = tsr_pkg::ST_ADDR;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
    end else if (stop_det) begin
      state_next = tsr_pkg::ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      case (state_reg)
        tsr_pkg::ST_ADDR,
        tsr_pkg::ST_CMD,
        tsr_pkg::ST_WDATA: begin
          if (scl_rise && cnt_reg != tsr_pkg::BYTE_BITS) begin
            shift_next = {shift_reg[6:0], sda_sync_reg};
            cnt_next   = cnt_reg + 4'h1;
          end else if (byte_done) begin
            state_next = tsr_pkg::ST_ACK;
            oe_next    = 1'b1;
            if (state_reg == tsr_pkg::ST_ADDR) begin
              after_next = shift_reg[0] ? tsr_pkg::ST_READ
                                        : tsr_pkg::ST_CMD;
              if (!addr_hit) begin
                state_next = tsr_pkg::ST_IDLE;
                oe_next    = 1'b0;
              end
            end else if (state_reg == tsr_pkg::ST_CMD) begin
              after_next = tsr_pkg::ST_WDATA;
              if (cmd_temp || cmd_cfg) begin
                ptr_cfg_next = cmd_cfg;
              end else begin
                state_next = tsr_pkg::ST_IDLE;
                oe_next    = 1'b0;
              end
            end else begin
              after_next = tsr_pkg::ST_WDATA;
              if (ptr_cfg_reg) begin
                standby_next = shift_reg[tsr_pkg::CFG_STANDBY];
              end else begin
                state_next = tsr_pkg::ST_IDLE;
                oe_next    = 1'b0;
              end
            end
          end
        end
        tsr_pkg::ST_ACK: begin
          if (scl_fall) begin
            cnt_next   = 4'h0;
            state_next = after_reg;
            if (after_reg == tsr_pkg::ST_READ) begin
              shift_next = rd_data;
              oe_next    = ~rd_data[7];
            end else begin
              oe_next = 1'b0;
            end
          end
        end
        tsr_pkg::ST_READ: begin
          if (scl_fall) begin
            if (cnt_reg == tsr_pkg::LAST_BIT) begin
              oe_next    = 1'b0;
              state_next = tsr_pkg::ST_RACK;
            end else begin
              shift_next = {shift_reg[6:0], 1'b0};
              oe_next    = ~shift_reg[6];
              cnt_next   = cnt_reg + 4'h1;
            end
          end
        end
        tsr_pkg::ST_RACK: begin
          if (scl_rise) begin
            acked_next = ~sda_sync_reg;
          end else if (scl_fall) begin
            cnt_next = 4'h0;
            if (acked_reg) begin
              state_next = tsr_pkg::ST_READ;
              shift_next = rd_data;
              oe_next    = ~rd_data[7];
            end else begin
              state_next = tsr_pkg::ST_IDLE;
            end
          end
        end
        tsr_pkg::ST_IDLE: begin
          oe_next = 1'b0;
        end
        default: begin
          state_next = tsr_pkg::ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Data ready set and clear
  // ****************************************
  assign ready_next = standby_next ? 1'b0 :
                      conv_bus.result_valid ? 1'b1 : ready_reg;

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= scl_i;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_i;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  // ****************************************
  // Slave state
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg   <= tsr_pkg::ST_IDLE;
      after_reg   <= tsr_pkg::ST_IDLE;
      cnt_reg     <= 4'h0;
      shift_reg   <= 8'h00;
      oe_reg      <= 1'b0;
      ptr_cfg_reg <= 1'b0;
      acked_reg   <= 1'b0;
    end else begin
      state_reg   <= state_next;
      after_reg   <= after_next;
      cnt_reg     <= cnt_next;
      shift_reg   <= shift_next;
      oe_reg      <= oe_next;
      ptr_cfg_reg <= ptr_cfg_next;
      acked_reg   <= acked_next;
    end
  end

  // ****************************************
  // Register set
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      standby_reg   <= tsr_pkg::CFG_RESET[tsr_pkg::CFG_STANDBY];
      ready_reg     <= tsr_pkg::CFG_RESET[tsr_pkg::CFG_READY];
      temp_reg      <= tsr_pkg::TEMP_RESET;
      load_pend_reg <= 1'b0;
    end else begin
      standby_reg   <= standby_next;
      ready_reg     <= ready_next;
      load_pend_reg <= conv_bus.result_valid & ~standby_next;
      if (load_pend_reg && ready_reg && !standby_reg) begin
        temp_reg <= conv_bus.result_code;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sda_out_reg  <= 1'b0;
      sda_oe_o     <= 1'b0;
      standby_o    <= 1'b0;
      data_ready_o <= 1'b0;
    end else begin
      sda_out_reg  <= 1'b0;
      sda_oe_o     <= oe_next;
      standby_o    <= standby_next;
      data_ready_o <= ready_next;
    end
  end

  assign sda_o = sda_out_reg;

endmodule

/* File: sim/tsr_host_model.sv */
`timescale 1ns/1ps
module tsr_host_model #(
  parameter time Q = 50ns
) (
  // Bus lines, released data reads high
  output logic      scl_o,
  output logic      sda_drv_o,
  input  wire logic sda_i
);
  initial begin
    scl_o     = 1'b1;
    sda_drv_o = 1'b1;
  end

  // Also serves as repeated start
  task automatic start();
    sda_drv_o = 1'b1;
    #Q scl_o = 1'b1;
    #Q sda_drv_o = 1'b0;
    #Q scl_o = 1'b0;
    #Q;
  endtask

  task automatic stop();
    sda_drv_o = 1'b0;
    #Q scl_o = 1'b1;
    #Q sda_drv_o = 1'b1;
    #(2 * Q);
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack_out);
    logic [8:0] sh;
    logic [8:0] rx;
    sh = {d, ack_in};
    for (int i = 8; i >= 0; i--) begin
      sda_drv_o = sh[i];
      #Q scl_o = 1'b1;
      #Q rx[i] = sda_i;
      #Q scl_o = 1'b0;
      #Q;
    end
    q       = rx[8:1];
    ack_out = rx[0];
  endtask
endmodule

/* File: sim/tsr_sensor_checker.sv */
`timescale 1ns/1ps
module tsr_sensor_checker #(
  parameter int CONV_CYCLES = tsr_pkg::CONV_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic standby_o,
  input wire logic data_ready_o
);
  // Cycles spent in normal mode since reset or standby
  localparam int LO  = CONV_CYCLES - 3;
  localparam int HI  = CONV_CYCLES + 4;
  localparam int TOP = CONV_CYCLES + 8;
  int   wait_cnt;
  logic cnt_clr;
  assign cnt_clr = rst_i | standby_o;
  always_ff @(posedge sys_clk_i) begin
    if (cnt_clr) begin
      wait_cnt <= 0;
    end else if (wait_cnt < TOP) begin
      wait_cnt <= wait_cnt + 1;
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_scl_high3;
    scl_i [*3];
  endsequence
  sequence s_ready_up;
    $rose(data_ready_o);
  endsequence

  property p_reset_clear;
    $fell(rst_i) |-> !standby_o && !data_ready_o;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("flags not clear after reset");
  property p_standby_no_ready;
    standby_o |-> !data_ready_o;
  endproperty
  a_standby_no_ready: assert property (p_standby_no_ready)
    else $error("ready set while in standby");
  property p_ready_fall;
    $fell(data_ready_o) |-> standby_o;
  endproperty
  a_ready_fall: assert property (p_ready_fall)
    else $error("ready dropped without standby");
  property p_ready_normal;
    s_ready_up |-> !$past(standby_o);
  endproperty
  a_ready_normal: assert property (p_ready_normal)
    else $error("conversion finished during standby");
  property p_ready_first;
    s_ready_up |-> wait_cnt >= LO && wait_cnt <= HI;
  endproperty
  a_ready_first: assert property (p_ready_first)
    else $error("first conversion at wrong time");
  property p_ready_bound;
    !data_ready_o && !standby_o |-> wait_cnt <= HI;
  endproperty
  a_ready_bound: assert property (p_ready_bound)
    else $error("no conversion result in normal mode");
  property p_sda_low;
    sda_oe_o |-> !sda_o;
  endproperty
  a_sda_low: assert property (p_sda_low)
    else $error("data line driven high");
  property p_oe_steady;
    s_scl_high3 |-> $stable(sda_oe_o);
  endproperty
  a_oe_steady: assert property (p_oe_steady)
    else $error("data drive changed while clock high");
endmodule

bind tsr_sensor_top tsr_sensor_checker #(
  .CONV_CYCLES (CONV_CYCLES)
) i_tsr_sensor_checker (
  .sys_clk_i    (sys_clk_i),
  .rst_i        (rst_i),
  .scl_i        (scl_i),
  .sda_o        (sda_o),
  .sda_oe_o     (sda_oe_o),
  .standby_o    (standby_o),
  .data_ready_o (data_ready_o)
);

/* File: sim/tb_tsr_sensor_top.sv */
`timescale 1ns/1ps
module tb_tsr_sensor_top;
  localparam int          CONV = 2000;
  localparam logic [7:0]  AW   = {tsr_pkg::DEV_ADDR, 1'b0};
  localparam logic [7:0]  AR   = {tsr_pkg::DEV_ADDR, 1'b1};
  // Quarter degree samples and their register codes
  localparam logic [11:0] SMP [12] = '{12'h208, 12'h1FC, 12'h1FA,
    12'h065, 12'h002, 12'h001, 12'hFFF, 12'hFFC, 12'hF9B, 12'hF24,
    12'hEFC, 12'h800};
  localparam logic [7:0]  CODE [12] = '{8'h7F, 8'h7F, 8'h7E, 8'h19,
    8'h00, 8'h00, 8'hFF, 8'hFF, 8'hE6, 8'hC9, 8'hBF, 8'h80};
  logic               sys_clk;
  logic               rst;
  logic               scl;
  logic               sda_drv;
  logic               sda_o;
  logic               sda_oe;
  logic signed [11:0] sensor;
  logic               standby;
  logic               ready;
  wire                sda;
  int                 n_mismatch;
  int                 tests_run;
  assign sda = sda_oe ? sda_o : sda_drv;

  tsr_sensor_top #(
    .CONV_CYCLES (CONV)
  ) i_tsr_sensor_top (
    .sys_clk_i     (sys_clk),
    .rst_i         (rst),
    .scl_i         (scl),
    .sda_i         (sda),
    .sda_o         (sda_o),
    .sda_oe_o      (sda_oe),
    .sensor_temp_i (sensor),
    .standby_o     (standby),
    .data_ready_o  (ready)
  );
  tsr_host_model i_tsr_host_model (
    .scl_o     (scl),
    .sda_drv_o (sda_drv),
    .sda_i     (sda)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ********
  // Tasks
  // ********
  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [7:0] d, input logic nack);
    logic [7:0] q;
    logic       a;
    i_tsr_host_model.xfer(d, 1'b1, q, a);
    check("ack", {7'h00, a}, {7'h00, nack});
  endtask
  task automatic wr(input logic [7:0] cmd, d, input logic nc, nd);
    i_tsr_host_model.start();
    put(AW, 1'b0);
    put(cmd, nc);
    if (!nc) begin
      put(d, nd);
    end
    i_tsr_host_model.stop();
  endtask
  // With cmd_en a read byte, otherwise a receive byte
  task automatic rd(input logic cmd_en, input logic [7:0] cmd, exp);
    logic [7:0] q;
    logic       a;
    i_tsr_host_model.start();
    if (cmd_en) begin
      put(AW, 1'b0);
      put(cmd, 1'b0);
      i_tsr_host_model.start();
    end
    put(AR, 1'b0);
    i_tsr_host_model.xfer(8'hFF, 1'b1, q, a);
    i_tsr_host_model.stop();
    check("read", q, exp);
  endtask
  task automatic wait_conv();
    repeat (CONV + 10) @(negedge sys_clk);
  endtask
  task automatic do_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("flags", {6'h00, standby, ready}, 8'h00);
  endtask

  // ********
  // Tests
  // ********
  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    rst        = 1'b1;
    sensor     = 12'h064;
    do_reset();
    rd(1'b1, 8'h00, 8'h00);
    rd(1'b1, 8'h01, 8'h00);
    wait_conv();
    rd(1'b1, 8'h01, 8'h40);
    rd(1'b1, 8'h00, 8'h19);
    for (int i = 0; i < 12; i++) begin
      sensor = SMP[i];
      wait_conv();
      rd(1'b0, 8'h00, CODE[i]);
    end
    wr(8'h00, 8'h55, 1'b0, 1'b1);
    rd(1'b0, 8'h00, 8'h80);
    wr(8'h02, 8'h00, 1'b1, 1'b1);
    rd(1'b0, 8'h00, 8'h80);
    wr(8'h01, 8'h3F, 1'b0, 1'b0);
    rd(1'b0, 8'h00, 8'h40);
    wr(8'h01, 8'hFF, 1'b0, 1'b0);
    check("flags", {6'h00, standby, ready}, 8'h02);
    rd(1'b0, 8'h00, 8'h80);
    sensor = 12'h0C8;
    wait_conv();
    wait_conv();
    rd(1'b1, 8'h00, 8'h80);
    wr(8'h01, 8'h00, 1'b0, 1'b0);
    rd(1'b0, 8'h00, 8'h00);
    wait_conv();
    rd(1'b0, 8'h00, 8'h40);
    rd(1'b1, 8'h00, 8'h32);
    i_tsr_host_model.start();
    put({tsr_pkg::DEV_ADDR ^ 7'h01, 1'b0}, 1'b1);
    i_tsr_host_model.stop();
    do_reset();
    rd(1'b1, 8'h00, 8'h00);
    end_of_test();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
